// ---- logic/sysref_gen_pkg.sv ----
// Constants, register map and carrier types of the SYSREF pattern generator.
// Assumes one clock (clk) and a byte-wide register access port on that clock.
//
// Summary of operation
// [R01] Input clock comes from the oscillator input or second-stage loop feedback.
// [R02] Fixed divide by two, then 16-bit divider K; total division is 2 x K.
// [R03] Divider K is split over byte registers 0x0400 (low) and 0x0401 (high).
// [R04] Pulses start only on divider boundaries, aligned to the other outputs.
// [R05] Bit 7 of 0x0402 selects software bits or the request pin as source.
// [R06] Software control is level sensitive; with bit 6 clear, bit 5 triggers.
// [R07] Software burst: bit 5 rising starts N pulses; device then clears bit 5.
// [R08] Software continuous: pulses run while bit 5 is one; clearing it stops.
// [R09] Pin level burst: pin rising starts N pulses; pin must drop before next.
// [R10] Pin level continuous: pin high runs the train, pin low stops it.
// [R11] Pin edge mode (bit 6 set): bit 5 picks rising or falling active edge.
// [R12] Edge burst: active edge starts N pulses; edges during the burst ignored.
// [R13] Edge continuous: an active edge starts the pulse train.
// [R14] Output mode 00: N pulses per request, then output held low.
// [R15] Burst code 001..101 gives 1,2,4,6,8 pulses; 110 and 111 give one.
// [R16] Output mode 01: continuous clock at input rate over 2 x K.
// [R17] Output mode 11 holds output low; code 10 is invalid.
// [R18] Generator drives SYSREF only when source mode bits 7:6 are 1x.
// [R19] Controller waits for loop lock before issuing any request.
// [R20] Each pulse is high K input periods, low K input periods.
// [R21] Burst code 000 is treated as a single pulse.

package sysref_gen_pkg;

   // Register offsets
   localparam logic [15:0] DIV_LOW_ADDR = 16'h0400;
   localparam logic [15:0] DIV_HIGH_ADDR = 16'h0401;
   localparam logic [15:0] TRIG_CTRL_ADDR = 16'h0402;
   localparam logic [15:0] OUT_CFG_ADDR = 16'h0403;

   // Values after reset
   localparam logic [7:0] DIV_LOW_RST = 8'h00;
   localparam logic [7:0] DIV_HIGH_RST = 8'h00;
   localparam logic [7:0] TRIG_CTRL_RST = 8'h00;
   localparam logic [7:0] OUT_CFG_RST = 8'h00;

   // Field positions in request_trigger_control
   localparam int PIN_CTRL_BIT = 7;
   localparam int EDGE_MODE_BIT = 6;
   localparam int TRIG_BIT = 5;
   localparam int CLK_SRC_BIT = 4;

   // Field positions in pattern_output_config
   localparam int SRC_MODE_BIT = 7;
   localparam int OUT_MODE_HI = 5;
   localparam int OUT_MODE_LO = 4;
   localparam int BURST_HI = 3;
   localparam int BURST_LO = 1;

   // Decoded configuration travelling into the generator core
   typedef struct packed {
      logic pin_ctrl;
      logic edge_mode;
      logic trig;
      logic clk_src;
      logic enabled;
      logic continuous;
      logic [3:0] burst_len;
   } gen_cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_BURST,
      ST_CONT,
      ST_HOLD
   } gen_state_t;

   // Burst code to pulse count; unlisted codes give one pulse
   function automatic logic [3:0] burst_len_of(input logic [2:0] code);
      logic [3:0] n;
      n = 4'h1;
      unique case (code)
         3'h2: n = 4'h2;
         3'h3: n = 4'h4;
         3'h4: n = 4'h6;
         3'h5: n = 4'h8;
         default: n = 4'h1;
      endcase
      return n;
   endfunction

endpackage

// ---- logic/request_pin_sync.sv ----
// Synchroniser and edge detector for the asynchronous run request pin.
// Assumes the pin may change at any time relative to clk.
`timescale 1ns/1ps

module request_pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Pin side
   input wire logic pin,
   // Synchronised results
   output logic level,
   output logic rise,
   output logic fall
);

   logic meta_r, meta_nxt;
   logic sync_r, sync_nxt;
   logic prev_r, prev_nxt;

   // First stage feeds only the second; edges look at stages two and three
   always_comb begin
      meta_nxt = pin;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;

endmodule

// ---- logic/pattern_divider.sv ----
// Free-running half-period timer: divide by K, then toggle (the fixed /2).
// Assumes tick is a one-cycle strobe per input clock period on clk.
`timescale 1ns/1ps

module pattern_divider #(
   parameter int KW = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Input clock strobe and divider value
   input wire logic tick,
   input wire logic [KW-1:0] k,
   // Period boundaries
   output logic phase,
   output logic rise_evt,
   output logic fall_evt
);

   logic [KW-1:0] cnt_r, cnt_nxt;
   logic phase_r, phase_nxt;
   logic [KW-1:0] k_last;
   logic wrap;

   // K of zero runs as one so the timer never stalls; >= copes with K shrinking
   always_comb begin
      k_last = (k == '0) ? '0 : k - 1'b1;
      wrap = tick && (cnt_r >= k_last); // R02 R20
      cnt_nxt = cnt_r;
      if (tick) begin
         cnt_nxt = wrap ? '0 : cnt_r + 1'b1;
      end
      phase_nxt = wrap ? ~phase_r : phase_r; // R02
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_r <= '0;
         phase_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         phase_r <= phase_nxt;
      end
   end

   assign phase = phase_r;
   assign rise_evt = wrap & ~phase_r;
   assign fall_evt = wrap & phase_r;

endmodule

// ---- logic/sysref_pattern_generator.sv ----
// SYSREF pattern generator: registers, request handling, pulse sequencing.
// Assumes osc_tick and loop_fb_tick are one-cycle strobes on clk, one per
// period of the oscillator input and the second-stage loop feedback node,
// and that the register access port is driven from logic on clk.
`timescale 1ns/1ps

module sysref_pattern_generator
   import sysref_gen_pkg::*;
#(
   parameter int KW = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Generator input clock strobes
   input wire logic osc_tick,
   input wire logic loop_fb_tick,
   // External request
   input wire logic run_request_pin,
   // Register write port
   input wire logic wr_en,
   input wire logic [15:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Register read port
   input wire logic rd_en,
   input wire logic [15:0] rd_addr,
   output logic [7:0] rd_data,
   // Pattern output and status
   output logic sysref_out,
   output logic gen_active
);

   // Register file
   logic [7:0] div_low_r, div_low_nxt;
   logic [7:0] div_high_r, div_high_nxt;
   logic [7:0] trig_ctrl_r, trig_ctrl_nxt;
   logic [7:0] out_cfg_r, out_cfg_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;

   // Sequencer state
   gen_state_t state_r, state_nxt;
   logic [3:0] pulses_r, pulses_nxt;
   logic pend_r, pend_nxt;
   logic out_r, out_nxt;
   logic active_r, active_nxt;
   logic hw_clr;

   // Decoded configuration and helper signals
   gen_cfg_t cfg;
   logic [KW-1:0] k_val;
   logic tick;
   logic pin_level, pin_rise, pin_fall;
   logic rise_evt, fall_evt;
   logic active_edge;
   logic go;
   logic stop_now;

   // Decode configuration from the register file
   always_comb begin
      k_val = KW'({div_high_r, div_low_r}); // R03
      cfg.pin_ctrl = trig_ctrl_r[PIN_CTRL_BIT]; // R05
      cfg.edge_mode = trig_ctrl_r[EDGE_MODE_BIT];
      cfg.trig = trig_ctrl_r[TRIG_BIT];
      cfg.clk_src = trig_ctrl_r[CLK_SRC_BIT];
      // Only source mode 1x with output mode 00 or 01 may drive pulses
      cfg.enabled = out_cfg_r[SRC_MODE_BIT]
         && !out_cfg_r[OUT_MODE_HI]; // R17 R18
      cfg.continuous = out_cfg_r[OUT_MODE_LO]; // R14 R16
      cfg.burst_len = burst_len_of(out_cfg_r[BURST_HI:BURST_LO]); // R15 R21
   end

   // Input clock select between oscillator and loop feedback strobes
   assign tick = cfg.clk_src ? loop_fb_tick : osc_tick; // R01

   request_pin_sync u_pin_sync (
      .clk(clk),
      .resetn(resetn),
      .pin(run_request_pin),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Timer runs freely so every start lands on a common boundary
   pattern_divider #(
      .KW(KW)
   ) u_divider (
      .clk(clk),
      .resetn(resetn),
      .tick(tick),
      .k(k_val),
      .phase(),
      .rise_evt(rise_evt),
      .fall_evt(fall_evt)
   );

   // Request qualification for each control method
   always_comb begin
      // In edge mode bit 5 chooses rising (1) or falling (0)
      active_edge = cfg.trig ? pin_rise : pin_fall; // R11
      if (!cfg.pin_ctrl) begin
         // Software control always follows the level of bit 5
         go = cfg.trig; // R06 R07 R08
      end else if (cfg.edge_mode) begin
         go = pend_r; // R12 R13
      end else begin
         // Level continuous also needs the pin still high at the boundary
         go = pend_r && (!cfg.continuous || pin_level); // R09 R10
      end
      if (!cfg.pin_ctrl) begin
         stop_now = !cfg.trig; // R08
      end else if (cfg.edge_mode) begin
         stop_now = pend_r;
      end else begin
         stop_now = !pin_level; // R10
      end
   end

   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      pulses_nxt = pulses_r;
      pend_nxt = pend_r;
      out_nxt = out_r;
      hw_clr = 1'b0;
      unique case (state_r)
         ST_IDLE: begin
            out_nxt = 1'b0;
            if (cfg.pin_ctrl) begin
               if (cfg.edge_mode ? active_edge : pin_rise) begin
                  pend_nxt = 1'b1;
               end
            end else begin
               pend_nxt = 1'b0;
            end
            // Starting only on a rising boundary keeps pulses aligned
            if (rise_evt && go) begin // R04
               out_nxt = 1'b1;
               pulses_nxt = '0;
               pend_nxt = 1'b0;
               state_nxt = cfg.continuous ? ST_CONT : ST_BURST;
            end
         end
         ST_BURST: begin
            // Edges and pin returns during a burst change nothing
            pend_nxt = 1'b0; // R12
            if (rise_evt) begin
               out_nxt = 1'b1; // R20
            end
            if (fall_evt) begin
               out_nxt = 1'b0;
               pulses_nxt = pulses_r + 4'h1;
               if (pulses_r + 4'h1 >= cfg.burst_len) begin // R14
                  pulses_nxt = '0;
                  if (!cfg.pin_ctrl) begin
                     hw_clr = 1'b1; // R07
                     state_nxt = ST_IDLE;
                  end else if (!cfg.edge_mode) begin
                     state_nxt = ST_HOLD; // R09
                  end else begin
                     state_nxt = ST_IDLE;
                  end
               end
            end
         end
         ST_CONT: begin
            // A further active edge in edge mode is kept as a stop request
            if (cfg.pin_ctrl && cfg.edge_mode && active_edge) begin
               pend_nxt = 1'b1;
            end
            if (rise_evt) begin
               out_nxt = 1'b1; // R16
            end
            if (fall_evt) begin
               out_nxt = 1'b0;
               // Stopping at a falling boundary never truncates a pulse
               if (stop_now) begin // R08 R10
                  pend_nxt = 1'b0;
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_HOLD: begin
            // Pin must return low before a new rising edge counts
            pend_nxt = 1'b0;
            if (!pin_level) begin // R09
               state_nxt = ST_IDLE;
            end
         end
      endcase
      // Stop or invalid mode, or an external source, forces output low
      if (!cfg.enabled) begin // R17 R18
         state_nxt = ST_IDLE;
         out_nxt = 1'b0;
         pend_nxt = 1'b0;
         pulses_nxt = '0;
      end
      active_nxt = (state_nxt != ST_IDLE);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         pulses_r <= '0;
         pend_r <= 1'b0;
         out_r <= 1'b0;
         active_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pulses_r <= pulses_nxt;
         pend_r <= pend_nxt;
         out_r <= out_nxt;
         active_r <= active_nxt;
      end
   end

   // Register writes; a software write in the clearing cycle wins
   always_comb begin
      div_low_nxt = div_low_r;
      div_high_nxt = div_high_r;
      trig_ctrl_nxt = trig_ctrl_r;
      out_cfg_nxt = out_cfg_r;
      if (hw_clr) begin
         trig_ctrl_nxt[TRIG_BIT] = 1'b0; // R07
      end
      if (wr_en) begin
         unique case (wr_addr)
            DIV_LOW_ADDR: div_low_nxt = wr_data; // R03
            DIV_HIGH_ADDR: div_high_nxt = wr_data; // R03
            TRIG_CTRL_ADDR: trig_ctrl_nxt = wr_data;
            OUT_CFG_ADDR: out_cfg_nxt = wr_data;
            default: ;
         endcase
      end
   end

   // Register reads answer one cycle later; unmapped offsets read zero
   always_comb begin
      rd_data_nxt = rd_data_r;
      if (rd_en) begin
         unique case (rd_addr)
            DIV_LOW_ADDR: rd_data_nxt = div_low_r;
            DIV_HIGH_ADDR: rd_data_nxt = div_high_r;
            TRIG_CTRL_ADDR: rd_data_nxt = trig_ctrl_r;
            OUT_CFG_ADDR: rd_data_nxt = out_cfg_r;
            default: rd_data_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_low_r <= DIV_LOW_RST;
         div_high_r <= DIV_HIGH_RST;
         trig_ctrl_r <= TRIG_CTRL_RST;
         out_cfg_r <= OUT_CFG_RST;
         rd_data_r <= 8'h00;
      end else begin
         div_low_r <= div_low_nxt;
         div_high_r <= div_high_nxt;
         trig_ctrl_r <= trig_ctrl_nxt;
         out_cfg_r <= out_cfg_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   // All outputs come straight from flip-flops
   assign sysref_out = out_r;
   assign gen_active = active_r;
   assign rd_data = rd_data_r;

endmodule

// ---- dv/sysref_gen_props.sv ----
// Port checker for the SYSREF pattern generator, attached by bind.
// Assumes the register shadows below see every write the design sees.
`timescale 1ns/1ps

module sysref_gen_props
   import sysref_gen_pkg::*;
#(
   parameter int KW = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Inputs
   input wire logic osc_tick,
   input wire logic loop_fb_tick,
   input wire logic wr_en,
   input wire logic [15:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   input wire logic [15:0] rd_addr,
   // Outputs
   input wire logic [7:0] rd_data,
   input wire logic sysref_out,
   input wire logic gen_active
);
   logic [15:0] k_r, k_nxt, hc_r, hc_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic [3:0] pc_r, pc_nxt, n;
   logic src_r, src_nxt, so_r, tk, frc;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // Shadows of written fields; hardware only clears trigger bit 5
   always_comb begin
      k_nxt = k_r;
      cfg_nxt = cfg_r;
      src_nxt = src_r;
      if (wr_en && wr_addr == DIV_LOW_ADDR)
         k_nxt[7:0] = wr_data;
      if (wr_en && wr_addr == DIV_HIGH_ADDR)
         k_nxt[15:8] = wr_data;
      if (wr_en && wr_addr == OUT_CFG_ADDR)
         cfg_nxt = wr_data;
      if (wr_en && wr_addr == TRIG_CTRL_ADDR)
         src_nxt = wr_data[CLK_SRC_BIT];
      tk = src_r ? loop_fb_tick : osc_tick;
      frc = !cfg_r[SRC_MODE_BIT] || cfg_r[OUT_MODE_HI];
      hc_nxt = sysref_out ? hc_r + 16'(tk) : 16'h0000;
      pc_nxt = gen_active ? pc_r + 4'(sysref_out && !so_r) : 4'h0;
      case (cfg_r[BURST_HI:BURST_LO])
         3'h2: n = 4'h2;
         3'h3: n = 4'h4;
         3'h4: n = 4'h6;
         3'h5: n = 4'h8;
         default: n = 4'h1;
      endcase
   end

   // Counters restart on reset so a mid-run reset leaves no stale count
   always_ff @(posedge clk) begin
      if (!resetn) begin
         k_r <= 16'h0000;
         cfg_r <= 8'h00;
         src_r <= 1'b0;
         hc_r <= 16'h0000;
         pc_r <= 4'h0;
         so_r <= 1'b0;
      end else begin
         k_r <= k_nxt;
         cfg_r <= cfg_nxt;
         src_r <= src_nxt;
         hc_r <= hc_nxt;
         pc_r <= pc_nxt;
         so_r <= sysref_out;
      end
   end

   // A pulse or a burst ending on its own, not cut by a forced stop
   sequence pulse_end;
      $fell(sysref_out) && !frc;
   endsequence
   sequence burst_end;
      $fell(gen_active) && !frc && cfg_r[OUT_MODE_HI:OUT_MODE_LO] == 2'h0;
   endsequence

   unmapped_read_a: assert property (rd_en && rd_addr[15:2] != 14'h0100
      |=> rd_data == 8'h00) else $error("unmapped read not zero");
   div_readback_a: assert property (rd_en && rd_addr == DIV_LOW_ADDR
      |=> rd_data == 8'($past(k_r))) else $error("divider readback");
   read_hold_a: assert property (!rd_en |=> $stable(rd_data))
      else $error("read data moved");
   forced_low_a: assert property (frc && $past(frc)
      |-> !sysref_out && !gen_active) else $error("output not held low");
   out_active_a: assert property (sysref_out |-> gen_active)
      else $error("pulse while idle");
   high_width_a: assert property (pulse_end
      |-> hc_r == ((k_r == 16'h0000) ? 16'h0001 : k_r))
      else $error("pulse width wrong");
   rise_aligned_a: assert property ($rose(sysref_out) |-> $past(tk))
      else $error("rise off boundary");
   burst_count_a: assert property (burst_end |-> pc_r == n)
      else $error("burst count wrong");
endmodule

bind sysref_pattern_generator sysref_gen_props #(.KW(KW)) u_props (
   .clk(clk), .resetn(resetn), .osc_tick(osc_tick),
   .loop_fb_tick(loop_fb_tick), .wr_en(wr_en), .wr_addr(wr_addr),
   .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
   .rd_data(rd_data), .sysref_out(sysref_out), .gen_active(gen_active));

// ---- dv/req_host_model.sv ----
// Host-side model that drives the run request pin.
// Assumes the bench supplies the wanted level and a loop lock flag on clk.
`timescale 1ns/1ps

module req_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Bench controls
   input wire logic lock,
   input wire logic want,
   // Pin
   output logic run_request_pin
);
   // Pin follows the wanted level only once the loop reports lock
   always_ff @(posedge clk) begin
      if (!resetn)
         run_request_pin <= 1'b0;
      else if (lock)
         run_request_pin <= want;
   end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the SYSREF pattern generator.
// Assumes 50 MHz clk; oscillator ticks every cycle, loop every third.
`timescale 1ns/1ps

module tb;
   import sysref_gen_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, osc_tick = 1'b1, loop_fb_tick = 1'b0;
   logic lock = 1'b0, want = 1'b0, pin, wr_en = 1'b0, rd_en = 1'b0;
   logic [15:0] wr_addr = 16'h0000, rd_addr = 16'h0000;
   logic [7:0] wr_data = 8'h00, rd_data;
   logic sysref_out, gen_active;
   logic [1:0] ph = 2'h0;
   int n_errors = 0, check_count = 0, pulses, hi;

   sysref_pattern_generator #(.KW(16)) u_dut (
      .clk(clk), .resetn(resetn), .osc_tick(osc_tick),
      .loop_fb_tick(loop_fb_tick), .run_request_pin(pin),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .sysref_out(sysref_out), .gen_active(gen_active));
   req_host_model u_host (.clk(clk), .resetn(resetn), .lock(lock),
      .want(want), .run_request_pin(pin));

   // Clock; loop strobe at a third of the rate to tell sources apart
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      loop_fb_tick <= (ph == 2'h2);
   end

   task automatic chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data === e, "read data");
   endtask
   task automatic set_pin(input logic v);
      @(posedge clk);
      want <= v;
   endtask
   // Counts rising edges and high cycles; keep adds to earlier counts
   task automatic run(input int cyc, input bit keep = 1'b0);
      logic p;
      p = sysref_out;
      if (!keep) begin
         pulses = 0;
         hi = 0;
      end
      repeat (cyc) begin
         @(negedge clk);
         if (sysref_out === 1'b1 && p !== 1'b1) pulses++;
         if (sysref_out === 1'b1) hi++;
         p = sysref_out;
      end
   endtask

   task automatic t_regs();
      for (int i = 0; i < 5; i++) rd(16'h0400 + 16'(i), 8'h00);
      wr(DIV_LOW_ADDR, 8'h02);
      wr(DIV_HIGH_ADDR, 8'h00);
      rd(DIV_LOW_ADDR, 8'h02);
      $display("regs test done");
   endtask
   task automatic t_sw_burst();
      int ex [8] = '{1, 1, 2, 4, 6, 8, 1, 1};
      for (int c = 0; c < 8; c++) begin
         wr(OUT_CFG_ADDR, 8'h80 | 8'(c << 1));
         wr(TRIG_CTRL_ADDR, 8'h20);
         run(60);
         chk(pulses == ex[c], "burst count");
         chk(gen_active === 1'b0, "idle after burst");
         rd(TRIG_CTRL_ADDR, 8'h00);
      end
      $display("software burst test done");
   endtask
   task automatic t_sw_cont();
      wr(OUT_CFG_ADDR, 8'h90);
      // Bit 6 set under software control still leaves bit 5 as the trigger
      wr(TRIG_CTRL_ADDR, 8'h60);
      run(40);
      chk(pulses >= 9 && pulses <= 10, "train rate");
      wr(TRIG_CTRL_ADDR, 8'h00);
      run(12);
      chk(sysref_out === 1'b0 && gen_active === 1'b0, "stop");
      $display("software continuous test done");
   endtask
   task automatic t_stop();
      logic [7:0] cf [3] = '{8'hb0, 8'ha0, 8'h02};
      for (int c = 0; c < 3; c++) begin
         wr(OUT_CFG_ADDR, cf[c]);
         wr(TRIG_CTRL_ADDR, 8'h20);
         run(30);
         chk(pulses == 0, "static low");
         wr(TRIG_CTRL_ADDR, 8'h00);
      end
      $display("stop test done");
   endtask
   task automatic t_clk_src();
      wr(TRIG_CTRL_ADDR, 8'h10);
      wr(OUT_CFG_ADDR, 8'h82);
      wr(TRIG_CTRL_ADDR, 8'h30);
      run(60);
      chk(pulses == 1 && hi == 6, "loop source width");
      rd(TRIG_CTRL_ADDR, 8'h10);
      wr(TRIG_CTRL_ADDR, 8'h00);
      $display("clock source test done");
   endtask
   task automatic t_pin_level();
      wr(OUT_CFG_ADDR, 8'h84);
      wr(TRIG_CTRL_ADDR, 8'h80);
      set_pin(1'b1);
      run(40);
      chk(pulses == 2, "pin burst");
      run(20);
      chk(pulses == 0, "no repeat while high");
      set_pin(1'b0);
      run(10);
      chk(gen_active === 1'b0, "idle after pin low");
      wr(OUT_CFG_ADDR, 8'h90);
      set_pin(1'b1);
      run(40);
      chk(pulses >= 8, "pin train");
      set_pin(1'b0);
      run(15);
      chk(sysref_out === 1'b0 && gen_active === 1'b0, "pin stop");
      $display("pin level test done");
   endtask
   task automatic t_pin_edge();
      wr(DIV_LOW_ADDR, 8'h04);
      wr(OUT_CFG_ADDR, 8'h84);
      wr(TRIG_CTRL_ADDR, 8'hc0);
      set_pin(1'b1);
      run(10);
      chk(pulses == 0, "inactive edge");
      set_pin(1'b0);
      run(6);
      set_pin(1'b1);
      run(3, 1'b1);
      set_pin(1'b0);
      run(40, 1'b1);
      chk(pulses == 2, "edge burst");
      wr(TRIG_CTRL_ADDR, 8'he0);
      wr(OUT_CFG_ADDR, 8'h90);
      set_pin(1'b1);
      run(40);
      chk(pulses >= 4, "edge train");
      set_pin(1'b0);
      set_pin(1'b1);
      run(30);
      chk(gen_active === 1'b0, "edge train stop");
      set_pin(1'b0);
      wr(DIV_LOW_ADDR, 8'h02);
      $display("pin edge test done");
   endtask
   task automatic t_reset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(DIV_LOW_ADDR, 8'h00);
      $display("reset test done");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog well beyond the thousand or so cycles the tests need
   initial begin
      #200000;
      n_errors++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      tally_and_finish();
   end

   // Main sequence; requests only after lock is reported
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      lock <= 1'b1;
      t_regs();
      t_sw_burst();
      t_sw_cont();
      t_stop();
      t_clk_src();
      t_pin_level();
      t_pin_edge();
      t_reset();
      tally_and_finish();
   end
endmodule
